// ### verilog/bit_skip_clear_call_regs.svh
// Opcode patterns, field positions and reset values for the skip, clear and call decoder.
// Included by bare name from the decoder package and modules.
`ifndef BIT_SKIP_CLEAR_CALL_REGS_SVH
`define BIT_SKIP_CLEAR_CALL_REGS_SVH

`define INSTR_W          14
`define PC_W             13
`define REG_ADDR_W       7
`define DATA_W           8
`define BIT_SEL_W        3
`define TARGET_W         11

`define SKIP_TOP_MSB     13
`define SKIP_TOP_LSB     10
`define SKIP_TOP_CODE    4'h7
`define BIT_SEL_MSB      9
`define BIT_SEL_LSB      7

`define CLEAR_TOP_MSB    13
`define CLEAR_TOP_LSB    7
`define CLEAR_TOP_CODE   7'h03
`define CLEAR_VALUE      8'h00

`define CALL_TOP_MSB     13
`define CALL_TOP_LSB     11
`define CALL_TOP_CODE    3'h4

`define REG_ADDR_MSB     6
`define REG_ADDR_LSB     0
`define TARGET_MSB       10
`define TARGET_LSB       0

`define PCH_SRC_MSB      4
`define PCH_SRC_LSB      3

`define RST_PULSE        1'h0
`define RST_ADDR         7'h00
`define RST_DATA         8'h00
`define RST_PC           13'h0000

`endif

// ### verilog/bit_skip_clear_call_pkg.sv
// Types shared by the skip, clear and call decoder modules.
// Assumes the constants header is on the include path.
`include "bit_skip_clear_call_regs.svh"

package bit_skip_clear_call_pkg;

   typedef enum logic [1:0]
   {
      ST_EXEC  = 2'h1,
      ST_FLUSH = 2'h2
   } exec_state_t;

   typedef logic [`INSTR_W-1:0]    instr_word_t;
   typedef logic [`PC_W-1:0]       pc_word_t;
   typedef logic [`REG_ADDR_W-1:0] reg_addr_t;
   typedef logic [`DATA_W-1:0]     data_byte_t;

endpackage

// ### verilog/decode_fields_if.sv
// Decoded instruction fields passed from the classifier to the executing logic.
// Purely combinational; no clock inside.
`timescale 1ns/1ps
`include "bit_skip_clear_call_regs.svh"

interface decode_fields_if;
   logic                      is_skip;
   logic                      is_clear;
   logic                      is_call;
   logic [`BIT_SEL_W-1:0]     bit_sel;
   logic [`REG_ADDR_W-1:0]    reg_addr;
   logic [`TARGET_W-1:0]      target;

   modport producer
   (
      output is_skip,
      output is_clear,
      output is_call,
      output bit_sel,
      output reg_addr,
      output target
   );

   modport consumer
   (
      input  is_skip,
      input  is_clear,
      input  is_call,
      input  bit_sel,
      input  reg_addr,
      input  target
   );
endinterface

// ### verilog/instr_classify.sv
// Combinational classifier for the skip, clear and call opcodes.
// Assumes the instruction word is stable while it is presented.
`timescale 1ns/1ps
`include "bit_skip_clear_call_regs.svh"

module instr_classify
(
   input  wire logic [`INSTR_W-1:0] instr,
   decode_fields_if.producer        fields
);

   always_comb
   begin
      fields.is_skip  = (instr[`SKIP_TOP_MSB:`SKIP_TOP_LSB] == `SKIP_TOP_CODE);
      fields.is_clear = (instr[`CLEAR_TOP_MSB:`CLEAR_TOP_LSB] == `CLEAR_TOP_CODE);
      fields.is_call  = (instr[`CALL_TOP_MSB:`CALL_TOP_LSB] == `CALL_TOP_CODE);
      fields.bit_sel  = instr[`BIT_SEL_MSB:`BIT_SEL_LSB];
      fields.reg_addr = instr[`REG_ADDR_MSB:`REG_ADDR_LSB];
      fields.target   = instr[`TARGET_MSB:`TARGET_LSB];
   end

endmodule // instr_classify

// ### verilog/bit_skip_clear_call_decode.sv
// Execute logic for the skip-if-bit-set, clear-register and call instructions.
// Assumes the fetch stage presents one instruction per cycle with instr_valid, the
// register file answers reg_rd_addr combinationally on reg_rd_data, and the stack and
// program counter act on the registered one-cycle strobes.
`timescale 1ns/1ps
`include "bit_skip_clear_call_regs.svh"

module bit_skip_clear_call_decode
(
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire logic                   instr_valid,
   input  wire logic [`INSTR_W-1:0]    instr,
   input  wire logic [`PC_W-1:0]       pc_current,
   input  wire logic [`DATA_W-1:0]     pc_high_latch,
   input  wire logic [`DATA_W-1:0]     reg_rd_data,
   output logic      [`REG_ADDR_W-1:0] reg_rd_addr,
   output logic                        reg_wr_en,
   output logic      [`REG_ADDR_W-1:0] reg_wr_addr,
   output logic      [`DATA_W-1:0]     reg_wr_data,
   output logic                        zero_flag_set,
   output logic                        stack_push,
   output logic      [`PC_W-1:0]       stack_push_data,
   output logic                        pc_load,
   output logic      [`PC_W-1:0]       pc_load_value,
   output logic                        discard_fetch,
   output logic                        skip_taken
);

   decode_fields_if fields ();

   instr_classify u_classify
   (
      .instr  (instr),
      .fields (fields)
   );

   bit_skip_clear_call_pkg::exec_state_t state_r;
   bit_skip_clear_call_pkg::exec_state_t state_nxt;

   logic                    wr_en_r;
   logic                    wr_en_nxt;
   logic [`REG_ADDR_W-1:0]  wr_addr_r;
   logic [`REG_ADDR_W-1:0]  wr_addr_nxt;
   logic [`DATA_W-1:0]      wr_data_r;
   logic [`DATA_W-1:0]      wr_data_nxt;
   logic                    zset_r;
   logic                    zset_nxt;
   logic                    push_r;
   logic                    push_nxt;
   logic [`PC_W-1:0]        push_data_r;
   logic [`PC_W-1:0]        push_data_nxt;
   logic                    load_r;
   logic                    load_nxt;
   logic [`PC_W-1:0]        load_val_r;
   logic [`PC_W-1:0]        load_val_nxt;
   logic                    skip_r;
   logic                    skip_nxt;
   logic                    accept;
   logic                    take_skip;
   logic                    take_clear;
   logic                    take_call;
   logic                    bit_is_one;
   logic [`PC_W-1:0]        pc_plus_one;

   // The register file is read at the address of the presented word in the same cycle.
   assign reg_rd_addr = fields.reg_addr;
   assign bit_is_one  = reg_rd_data[fields.bit_sel];
   assign pc_plus_one = pc_current + `PC_W'(1);

   // While flushing, the presented word is the discarded prefetch and is not executed.
   assign accept = instr_valid && (state_r == bit_skip_clear_call_pkg::ST_EXEC);

   // Opcode encodings are disjoint, so at most one of these is high in a cycle.
   assign take_skip  = accept && fields.is_skip && bit_is_one;
   assign take_clear = accept && fields.is_clear;
   assign take_call  = accept && fields.is_call;

   // Sequencing: a taken skip or a call spends the next cycle discarding the prefetch.
   always_comb
   begin
      state_nxt = bit_skip_clear_call_pkg::ST_EXEC;
      skip_nxt  = 1'b0;
      case (state_r)
         bit_skip_clear_call_pkg::ST_EXEC:
         begin
            if (take_skip)
            begin
               // No status flag is touched by a skip, taken or not.
               skip_nxt  = 1'b1;
               state_nxt = bit_skip_clear_call_pkg::ST_FLUSH;
            end
            else if (take_call)
            begin
               state_nxt = bit_skip_clear_call_pkg::ST_FLUSH;
            end
         end
         bit_skip_clear_call_pkg::ST_FLUSH:
         begin
            state_nxt = bit_skip_clear_call_pkg::ST_EXEC;
         end
         default:
         begin
            state_nxt = bit_skip_clear_call_pkg::ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= bit_skip_clear_call_pkg::ST_EXEC;
         skip_r  <= `RST_PULSE;
      end
      else
      begin
         state_r <= state_nxt;
         skip_r  <= skip_nxt;
      end
   end

   // Register write port: a clear writes zero to its register and forces the zero flag.
   always_comb
   begin
      wr_en_nxt   = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      zset_nxt    = 1'b0;
      if (take_clear)
      begin
         wr_en_nxt   = 1'b1;
         wr_addr_nxt = fields.reg_addr;
         wr_data_nxt = `CLEAR_VALUE;
         zset_nxt    = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_en_r   <= `RST_PULSE;
         wr_addr_r <= `RST_ADDR;
         wr_data_r <= `RST_DATA;
         zset_r    <= `RST_PULSE;
      end
      else
      begin
         wr_en_r   <= wr_en_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         zset_r    <= zset_nxt;
      end
   end

   // Stack port: a call pushes the address of the word after itself.
   always_comb
   begin
      push_nxt      = 1'b0;
      push_data_nxt = push_data_r;
      if (take_call)
      begin
         push_nxt      = 1'b1;
         push_data_nxt = pc_plus_one;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         push_r      <= `RST_PULSE;
         push_data_r <= `RST_PC;
      end
      else
      begin
         push_r      <= push_nxt;
         push_data_r <= push_data_nxt;
      end
   end

   // Counter load: the target fills the low bits, the high latch the top two.
   always_comb
   begin
      load_nxt     = 1'b0;
      load_val_nxt = load_val_r;
      if (take_call)
      begin
         load_nxt     = 1'b1;
         load_val_nxt = {pc_high_latch[`PCH_SRC_MSB:`PCH_SRC_LSB],
                         fields.target};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         load_r     <= `RST_PULSE;
         load_val_r <= `RST_PC;
      end
      else
      begin
         load_r     <= load_nxt;
         load_val_r <= load_val_nxt;
      end
   end

   assign reg_wr_en       = wr_en_r;
   assign reg_wr_addr     = wr_addr_r;
   assign reg_wr_data     = wr_data_r;
   assign zero_flag_set   = zset_r;
   assign stack_push      = push_r;
   assign stack_push_data = push_data_r;
   assign pc_load         = load_r;
   assign pc_load_value   = load_val_r;
   assign skip_taken      = skip_r;
   assign discard_fetch   = (state_r == bit_skip_clear_call_pkg::ST_FLUSH);

endmodule // bit_skip_clear_call_decode

// ### verification/bit_skip_clear_call_properties.sv
// Concurrent checks on the skip, clear and call decoder ports.
// Assumes it is bound to the decoder top module.
`timescale 1ns/1ps

module bit_skip_clear_call_checker
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        instr_valid,
   input wire logic [13:0] instr,
   input wire logic [12:0] pc_current,
   input wire logic [7:0]  pc_high_latch,
   input wire logic [7:0]  reg_rd_data,
   input wire logic        reg_wr_en,
   input wire logic [6:0]  reg_wr_addr,
   input wire logic [7:0]  reg_wr_data,
   input wire logic        zero_flag_set,
   input wire logic        stack_push,
   input wire logic [12:0] stack_push_data,
   input wire logic        pc_load,
   input wire logic [12:0] pc_load_value,
   input wire logic        discard_fetch,
   input wire logic        skip_taken
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire take = instr_valid && !discard_fetch;
   wire skp  = take && instr[13:10] == 4'h7;
   wire clr  = take && instr[13:7] == 7'h03;
   wire cal  = take && instr[13:11] == 3'h4;
   wire hit  = reg_rd_data[instr[9:7]];
   skip_hit_a: assert property (skp && hit |=> skip_taken && discard_fetch)
      else $error("taken skip missing");
   skip_miss_a: assert property (skp && !hit |=> !skip_taken && !discard_fetch)
      else $error("untaken skip acted");
   skip_nop_a: assert property ($rose(skip_taken) |-> discard_fetch ##1 !discard_fetch)
      else $error("skip flush length wrong");
   flush_ignore_a: assert property (discard_fetch |=> !(reg_wr_en || zero_flag_set
      || stack_push || pc_load || skip_taken))
      else $error("discarded word acted");
   skip_flags_a: assert property (skp |=> !zero_flag_set && !reg_wr_en)
      else $error("skip touched flags");
   clear_write_a: assert property (clr |=> reg_wr_en && zero_flag_set && reg_wr_data == 8'h00
      && reg_wr_addr == $past(instr[6:0]))
      else $error("clear write wrong");
   call_push_a: assert property (cal |=> stack_push && pc_load && stack_push_data - 13'h0001
      == $past(pc_current) && pc_load_value[10:0] == $past(instr[10:0]))
      else $error("call push or load wrong");
   call_high_a: assert property (cal |=> discard_fetch
      && pc_load_value[12:11] == $past(pc_high_latch[4:3]))
      else $error("call high bits wrong");
endmodule // bit_skip_clear_call_checker

bind bit_skip_clear_call_decode bit_skip_clear_call_checker i_checker
(
   .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
   .pc_current(pc_current), .pc_high_latch(pc_high_latch), .reg_rd_data(reg_rd_data),
   .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
   .zero_flag_set(zero_flag_set), .stack_push(stack_push), .stack_push_data(stack_push_data),
   .pc_load(pc_load), .pc_load_value(pc_load_value), .discard_fetch(discard_fetch),
   .skip_taken(skip_taken)
);

// ### verification/bit_skip_clear_call_decode_test.sv
// Self-checking bench for the skip, clear and call decoder.
// Assumes the checker file is compiled beside it.
`timescale 1ns/1ps

module bit_skip_clear_call_decode_test;
   typedef struct packed
   {
      logic        v;
      logic [13:0] i;
      logic [7:0]  d;
      logic [12:0] p;
      logic [7:0]  h;
      logic [5:0]  s;
      logic [12:0] e;
   } row_t;
   logic ref_clk = 0, rstn = 0, instr_valid = 0;
   bit_skip_clear_call_pkg::instr_word_t instr = 14'h0000;
   bit_skip_clear_call_pkg::pc_word_t pc_current = 13'h0000, stack_push_data, pc_load_value;
   bit_skip_clear_call_pkg::data_byte_t pc_high_latch = 8'h00, reg_rd_data = 8'h00, reg_wr_data;
   bit_skip_clear_call_pkg::reg_addr_t reg_rd_addr, reg_wr_addr;
   logic reg_wr_en, zero_flag_set, stack_push, pc_load, discard_fetch, skip_taken;
   wire [5:0] strobes = {reg_wr_en, zero_flag_set, stack_push, pc_load, discard_fetch, skip_taken};
   int n_mismatch = 0, check_count = 0;
   // Each row follows the one before it, so a word after a flushing row is refused.
   row_t rows [13] = '{
      '{1'h1, 14'h01ff, 8'h00, 13'h0, 8'h00, 6'h30, 13'h0},
      '{1'h1, 14'h0180, 8'h00, 13'h0, 8'h00, 6'h30, 13'h0},
      '{1'h1, 14'h1f85, 8'h80, 13'h0, 8'h00, 6'h03, 13'h0},
      '{1'h1, 14'h0185, 8'h00, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h1, 14'h1c05, 8'hfe, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h1, 14'h1dff, 8'h08, 13'h0, 8'h00, 6'h03, 13'h0},
      '{1'h1, 14'h2000, 8'h00, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h1, 14'h27ff, 8'h00, 13'h1fff, 8'h18, 6'h0e, 13'h1fff},
      '{1'h1, 14'h1f85, 8'h80, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h1, 14'h2000, 8'h00, 13'h0123, 8'h08, 6'h0e, 13'h0800},
      '{1'h1, 14'h1385, 8'hff, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h1, 14'h1385, 8'hff, 13'h0, 8'h00, 6'h00, 13'h0},
      '{1'h0, 14'h0185, 8'h00, 13'h0, 8'h00, 6'h00, 13'h0}};

   bit_skip_clear_call_decode i_bit_skip_clear_call_decode
   (
      .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
      .pc_current(pc_current), .pc_high_latch(pc_high_latch), .reg_rd_data(reg_rd_data),
      .reg_rd_addr(reg_rd_addr), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .zero_flag_set(zero_flag_set), .stack_push(stack_push),
      .stack_push_data(stack_push_data), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .discard_fetch(discard_fetch), .skip_taken(skip_taken)
   );

   task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (400) @(posedge ref_clk);
      n_mismatch++;
      finish_test;
   end

   initial
   begin
      repeat (4) @(negedge ref_clk);
      check("reset strobes", strobes, 6'h00);
      rstn = 1;
      @(negedge ref_clk);
      foreach (rows[k])
      begin
         @(negedge ref_clk);
         {instr_valid, instr, reg_rd_data, pc_current, pc_high_latch} =
            {rows[k].v, rows[k].i, rows[k].d, rows[k].p, rows[k].h};
         #1 check("rd_addr", reg_rd_addr, rows[k].i[6:0]);
         @(posedge ref_clk);
         #1 check("strobes", strobes, rows[k].s);
         if (rows[k].s[5])
         begin
            check("wr_addr", reg_wr_addr, rows[k].i[6:0]);
            check("wr_data", reg_wr_data, 8'h00);
         end
         if (rows[k].s[3])
         begin
            check("push", stack_push_data, 13'(rows[k].p + 13'h0001));
            check("load", pc_load_value, rows[k].e);
         end
      end
      @(negedge ref_clk);
      {instr_valid, instr} = {1'h1, 14'h2555};
      @(negedge ref_clk);
      rstn = 0;
      instr_valid = 0;
      #1 check("mid reset", strobes, 6'h00);
      check("mid reset load", pc_load_value, 13'h0000);
      @(negedge ref_clk);
      rstn = 1;
      @(negedge ref_clk);
      check("after reset", strobes, 6'h00);
      // Reset fell during a discard cycle, so the first word after it must be taken.
      {instr_valid, instr} = {1'h1, 14'h01aa};
      @(posedge ref_clk);
      #1 check("first after reset", strobes, 6'h30);
      check("first wr_addr", reg_wr_addr, 7'h2a);
      finish_test;
   end
endmodule // bit_skip_clear_call_decode_test
